// file: rtl/far_pkg.sv
package far_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_WORD = 8'h00;
    localparam logic [7:0] OFS_RESTART_CFG = 8'h04;
    localparam logic [7:0] OFS_UV_LIMIT = 8'h08;
    localparam logic [7:0] OFS_BB_TIME = 8'h0c;
    localparam logic [7:0] OFS_BB_EXT = 8'h10;
    localparam logic [7:0] OFS_BB_THRESH = 8'h14;
    localparam logic [7:0] OFS_DISP_OPT = 8'h18;
    localparam logic [7:0] OFS_QS_MODE = 8'h1c;
    localparam logic [7:0] OFS_STATUS_A = 8'h20;
    localparam logic [7:0] OFS_STATUS_B = 8'h24;
    localparam logic [7:0] OFS_STATE_DISP = 8'h28;
    localparam logic [7:0] OFS_OC_ATTEMPTS = 8'h2c;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h34;

    // field positions
    localparam int CW_RELEASE = 0;
    localparam int CW_ERR_RESET = 1;
    localparam int CW_QUICK_STOP = 8;
    localparam int CFG_UV_EN = 0;
    localparam int CFG_OV_EN = 1;
    localparam int CFG_OC_EN = 2;
    localparam int CFG_RESP_LSB = 4;
    localparam int CFG_CMS_LSB = 8;
    localparam int DISP_HIDE_BB = 8;
    localparam int QSM_CW_MOD_ON = 2;
    localparam int QSM_STATUS_OFF = 3;
    localparam int SW_RUNNING = 0;
    localparam int SW_ERROR = 3;
    localparam int SW_QUICK_STOP = 8;

    // reset values
    localparam logic [31:0] RST_CONTROL_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_RESTART_CFG = 32'h0000_0001;
    localparam logic [11:0] RST_UV_LIMIT = 12'h000;
    localparam logic [11:0] RST_BB_TIME = 12'h000;
    localparam logic [7:0] RST_BB_EXT = 8'h00;
    localparam logic [7:0] RST_BB_THRESH = 8'h00;
    localparam logic [15:0] RST_DISP_OPT = 16'h0000;
    localparam logic [4:0] RST_QS_MODE = 5'h00;

    // timing
    localparam int CLK_NS = 20;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_NS;
    localparam int BB_MIN_MS = 1000;
    localparam logic [12:0] BB_MIN_TICKS = 13'(BB_MIN_MS / TICK_MS);
    localparam int OC_GOOD_MS = 1000;
    localparam logic [6:0] OC_GOOD_TICKS = 7'(OC_GOOD_MS / TICK_MS);
    localparam logic [3:0] OC_MAX_ATTEMPTS = 4'ha;

    // malfunction responses
    localparam logic [2:0] RESP_ERROR = 3'h0;
    localparam logic [2:0] RESP_QS_OFF = 3'h1;
    localparam logic [2:0] RESP_QS_HOLD = 3'h2;
    localparam logic [2:0] RESP_OFF_RETRY = 3'h3;
    localparam logic [2:0] RESP_QS_OFF_RETRY = 3'h4;
    localparam logic [2:0] RESP_QS_HOLD_RETRY = 3'h5;
    localparam logic [2:0] RESP_IGNORE = 3'h6;

    // state display codes
    localparam logic [7:0] DISP_IDLE = 8'h00;
    localparam logic [7:0] DISP_RUN = 8'h01;
    localparam logic [7:0] DISP_UV = 8'h02;
    localparam logic [7:0] DISP_OV = 8'h03;
    localparam logic [7:0] DISP_OC = 8'h04;
    localparam logic [7:0] DISP_GEN = 8'h05;
    localparam logic [7:0] DISP_BASE_BLOCK = 8'h4c;
    localparam logic [7:0] DISP_QUICK_STOP = 8'h4f;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {K_NONE, K_CW, K_UV, K_OV, K_OC, K_GEN} far_kind_t;
endpackage

// file: rtl/far_top.sv
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module far_top
    import far_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = far_pkg::TICK_CYCLES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic undervolt_fault,
    input wire logic overvolt_fault,
    input wire logic overcurrent_fault,
    input wire logic general_fault,
    input wire logic standstill,
    input wire logic [7:0] modulation_grade,
    output logic modulation_enable,
    output logic quick_stop_active,
    output logic qs_ramp_select,
    output logic qs_torque_select,
    output logic error_condition,
    output logic irq
);
    import far_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_QSTOP, ST_OFF, ST_LOCKED} far_state_t;

    far_state_t state, next_state;
    far_kind_t kind, next_kind;
    logic [31:0] control_word, restart_cfg;
    logic [11:0] uv_limit, bb_time;
    logic [7:0] bb_ext, bb_thresh;
    logic [15:0] disp_opt;
    logic [4:0] qs_mode;
    logic err_reset;
    logic [3:0] irq_status, irq_mask, events;
    logic [3:0] sync1, sync2, sync3, flt;
    logic [31:0] tick_cnt;
    logic tick;
    logic [12:0] bb_cnt, bb_need, bb_eff;
    logic [11:0] uv_cnt;
    logic [6:0] good_cnt;
    logic [3:0] oc_attempts;
    logic [7:0] state_disp;
    logic uv_f, ov_f, oc_f, gen_f, any_fault, cause, bb_done, shutoff;
    logic err_bit, next_err_cond;
    logic [2:0] resp;
    logic aw_full, w_full, wr_go;
    logic [7:0] aw_addr;
    logic [31:0] w_data, wmask, rd_data;
    logic [3:0] wstrb_q;
    logic rd_hit;

    ////////////////////////////////////////////////////////////////////////////
    // fault input synchronisers and tick divider

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
            flt <= 4'h0;
        end else begin
            sync1 <= {general_fault, overcurrent_fault, overvolt_fault, undervolt_fault};
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < 4; i++) begin
                if (sync2[i] == sync3[i]) begin
                    flt[i] <= sync3[i];
                end
            end
        end
    end

    assign uv_f = flt[0];
    assign ov_f = flt[1];
    assign oc_f = flt[2];
    assign resp = restart_cfg[CFG_RESP_LSB +: 3];
    assign gen_f = flt[3] && (resp < RESP_IGNORE);
    assign any_fault = uv_f || ov_f || oc_f || gen_f;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == TICK_CYCLES - 1);
            tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        unique case (kind)
            K_UV: cause = uv_f;
            K_OV: cause = ov_f;
            K_OC: cause = oc_f;
            K_GEN: cause = gen_f;
            K_CW: cause = control_word[CW_QUICK_STOP];
            default: cause = 1'b0;
        endcase
    end

    assign bb_done = (bb_cnt >= bb_need);

    always_comb begin
        next_state = state;
        next_kind = kind;
        unique case (state)
            ST_IDLE: begin
                if (control_word[CW_RELEASE] && bb_done && !any_fault) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN, ST_QSTOP: begin
                if (oc_f) begin
                    next_kind = K_OC;
                    if (restart_cfg[CFG_OC_EN] &&
                        (oc_attempts < OC_MAX_ATTEMPTS || good_cnt >= OC_GOOD_TICKS)) begin
                        next_state = ST_OFF;
                    end else begin
                        next_state = ST_LOCKED;
                    end
                end else if (ov_f) begin
                    next_kind = K_OV;
                    next_state = restart_cfg[CFG_OV_EN] ? ST_OFF : ST_LOCKED;
                end else if (uv_f) begin
                    next_kind = K_UV;
                    next_state = restart_cfg[CFG_UV_EN] ? ST_OFF : ST_LOCKED;
                end else if (gen_f && kind != K_GEN) begin
                    next_kind = K_GEN;
                    if (resp == RESP_ERROR) begin
                        next_state = ST_LOCKED;
                    end else if (resp == RESP_OFF_RETRY) begin
                        next_state = ST_OFF;
                    end else begin
                        next_state = ST_QSTOP;
                    end
                end else if (state == ST_RUN) begin
                    if (!control_word[CW_RELEASE]) begin
                        next_state = ST_OFF;
                        next_kind = K_NONE;
                    end else if (control_word[CW_QUICK_STOP]) begin
                        next_state = ST_QSTOP;
                        next_kind = K_CW;
                    end
                end else if (kind == K_CW) begin
                    if (!control_word[CW_QUICK_STOP]) begin
                        next_state = ST_RUN;
                        next_kind = K_NONE;
                    end else if (standstill && !qs_mode[QSM_CW_MOD_ON]) begin
                        next_state = ST_OFF;
                    end
                end else if (standstill) begin
                    if (resp == RESP_QS_OFF) begin
                        next_state = ST_LOCKED;
                    end else if (resp == RESP_QS_OFF_RETRY) begin
                        next_state = ST_OFF;
                    end else if (!gen_f && (resp == RESP_QS_HOLD_RETRY ||
                                            (resp == RESP_QS_HOLD && err_reset))) begin
                        next_state = ST_RUN;
                        next_kind = K_NONE;
                    end
                end
            end
            ST_OFF: begin
                if (kind == K_UV && uv_limit != 12'h000 && uv_cnt >= uv_limit) begin
                    next_state = ST_LOCKED;
                end else if (!cause && bb_done) begin
                    next_state = control_word[CW_RELEASE] ? ST_RUN : ST_IDLE;
                    next_kind = K_NONE;
                end
            end
            ST_LOCKED: begin
                if (err_reset && !any_fault) begin
                    next_state = ST_IDLE;
                    next_kind = K_NONE;
                end
            end
        endcase
    end

    assign shutoff = (state == ST_RUN || state == ST_QSTOP) &&
                     !(next_state == ST_RUN || next_state == ST_QSTOP);
    assign next_err_cond = (next_state == ST_LOCKED) ||
                           (next_state == ST_OFF && next_kind >= K_UV);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            kind <= K_NONE;
            modulation_enable <= 1'b0;
            error_condition <= 1'b0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            modulation_enable <= (next_state == ST_RUN || next_state == ST_QSTOP);
            error_condition <= next_err_cond;
        end
    end

    // quick stop outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quick_stop_active <= 1'b0;
            qs_ramp_select <= 1'b0;
            qs_torque_select <= 1'b0;
        end else begin
            quick_stop_active <= (next_state == ST_QSTOP) &&
                                 !(qs_mode[QSM_STATUS_OFF] && standstill);
            qs_ramp_select <= (next_state == ST_QSTOP);
            qs_torque_select <= (next_state == ST_QSTOP) &&
                                (restart_cfg[CFG_CMS_LSB +: 3] >= 3'h4) &&
                                (restart_cfg[CFG_CMS_LSB +: 3] <= 3'h6);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // base block, undervoltage and overcurrent timing

    assign bb_eff = (bb_ext != 8'h00) ? 13'(bb_time) + 13'(bb_ext) : 13'(bb_time);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bb_cnt <= 13'h0000;
            bb_need <= 13'h0000;
        end else if (shutoff) begin
            bb_cnt <= 13'h0000;
            if (next_kind == K_OV || next_kind == K_OC) begin
                bb_need <= (bb_eff < BB_MIN_TICKS) ? BB_MIN_TICKS : bb_eff;
            end else begin
                bb_need <= (modulation_grade >= bb_thresh) ? bb_eff : 13'h0000;
            end
        end else if (tick && !bb_done) begin
            bb_cnt <= bb_cnt + 13'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uv_cnt <= 12'h000;
        end else if (!uv_f) begin
            uv_cnt <= 12'h000;
        end else if (tick && uv_cnt != 12'hfff) begin
            uv_cnt <= uv_cnt + 12'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            good_cnt <= 7'h00;
            oc_attempts <= 4'h0;
        end else begin
            if (!(state == ST_RUN || state == ST_QSTOP)) begin
                good_cnt <= 7'h00;
            end else if (tick && good_cnt < OC_GOOD_TICKS) begin
                good_cnt <= good_cnt + 7'h01;
            end
            if (state == ST_OFF && next_state == ST_RUN && kind == K_OC) begin
                oc_attempts <= (good_cnt >= OC_GOOD_TICKS) ? 4'h1 :
                               (oc_attempts == 4'hf) ? oc_attempts : oc_attempts + 4'h1;
            end else if (good_cnt >= OC_GOOD_TICKS) begin
                oc_attempts <= 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status and display

    assign err_bit = (state == ST_LOCKED) ||
                     (state == ST_OFF && kind >= K_UV && cause &&
                      !(kind == K_UV && uv_limit != 12'h000));

    always_comb begin
        unique case (kind)
            K_UV: state_disp = DISP_UV;
            K_OV: state_disp = DISP_OV;
            K_OC: state_disp = DISP_OC;
            K_GEN: state_disp = DISP_GEN;
            default: state_disp = DISP_IDLE;
        endcase
        if (state == ST_RUN) begin
            state_disp = DISP_RUN;
        end else if (state == ST_QSTOP) begin
            state_disp = DISP_QUICK_STOP;
        end else if (state == ST_OFF && !bb_done && !disp_opt[DISP_HIDE_BB]) begin
            state_disp = DISP_BASE_BLOCK;
        end
    end

    assign events = {state != ST_QSTOP && next_state == ST_QSTOP,
                     state != ST_LOCKED && next_state == ST_LOCKED,
                     state == ST_OFF && next_state == ST_RUN && kind >= K_UV,
                     shutoff};

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    assign wr_go = aw_full && w_full && !bvalid;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            aw_full <= 1'b0;
            aw_addr <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_full <= 1'b1;
            aw_addr <= awaddr;
        end else begin
            if (wr_go) begin
                aw_full <= 1'b0;
            end
            awready <= !aw_full && !bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b0;
            w_full <= 1'b0;
            w_data <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_full <= 1'b1;
            w_data <= wdata;
            wstrb_q <= wstrb;
        end else begin
            if (wr_go) begin
                w_full <= 1'b0;
            end
            wready <= !w_full && !bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= (aw_addr <= OFS_QS_MODE || aw_addr == OFS_IRQ_STATUS ||
                      aw_addr == OFS_IRQ_MASK) && aw_addr[1:0] == 2'h0 ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                          input logic [31:0] d);
        merge = (old & ~m) | (d & m);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_word <= RST_CONTROL_WORD;
            restart_cfg <= RST_RESTART_CFG;
            uv_limit <= RST_UV_LIMIT;
            bb_time <= RST_BB_TIME;
            bb_ext <= RST_BB_EXT;
            bb_thresh <= RST_BB_THRESH;
            disp_opt <= RST_DISP_OPT;
            qs_mode <= RST_QS_MODE;
            irq_mask <= 4'h0;
            err_reset <= 1'b0;
        end else begin
            err_reset <= 1'b0;
            if (wr_go) begin
                unique case (aw_addr)
                    OFS_CONTROL_WORD: begin
                        control_word <= merge(control_word, wmask, w_data) &
                                        ~(32'h0000_0001 << CW_ERR_RESET);
                        err_reset <= w_data[CW_ERR_RESET] & wmask[CW_ERR_RESET];
                    end
                    OFS_RESTART_CFG: restart_cfg <= merge(restart_cfg, wmask, w_data) &
                                                    32'h0000_0777;
                    OFS_UV_LIMIT: uv_limit <= 12'(merge(32'(uv_limit), wmask, w_data));
                    OFS_BB_TIME: bb_time <= 12'(merge(32'(bb_time), wmask, w_data));
                    OFS_BB_EXT: bb_ext <= 8'(merge(32'(bb_ext), wmask, w_data));
                    OFS_BB_THRESH: bb_thresh <= 8'(merge(32'(bb_thresh), wmask, w_data));
                    OFS_DISP_OPT: disp_opt <= 16'(merge(32'(disp_opt), wmask, w_data));
                    OFS_QS_MODE: qs_mode <= 5'(merge(32'(qs_mode), wmask, w_data));
                    OFS_IRQ_MASK: irq_mask <= 4'(merge(32'(irq_mask), wmask, w_data));
                    default: ;
                endcase
            end
        end
    end

    // sticky events, write one to clear, a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 4'h0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~((wr_go && aw_addr == OFS_IRQ_STATUS) ?
                                          (w_data[3:0] & wmask[3:0]) : 4'h0)) | events;
            irq <= |(irq_status & irq_mask);
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        unique case (araddr)
            OFS_CONTROL_WORD: rd_data = control_word;
            OFS_RESTART_CFG: rd_data = restart_cfg;
            OFS_UV_LIMIT: rd_data = 32'(uv_limit);
            OFS_BB_TIME: rd_data = 32'(bb_time);
            OFS_BB_EXT: rd_data = 32'(bb_ext);
            OFS_BB_THRESH: rd_data = 32'(bb_thresh);
            OFS_DISP_OPT: rd_data = 32'(disp_opt);
            OFS_QS_MODE: rd_data = 32'(qs_mode);
            OFS_STATUS_A, OFS_STATUS_B: begin
                rd_data = 32'h0000_0000;
                rd_data[SW_RUNNING] = modulation_enable;
                rd_data[SW_ERROR] = err_bit;
                rd_data[SW_QUICK_STOP] = quick_stop_active;
            end
            OFS_STATE_DISP: rd_data = 32'(state_disp);
            OFS_OC_ATTEMPTS: rd_data = 32'(oc_attempts);
            OFS_IRQ_STATUS: rd_data = 32'(irq_status);
            OFS_IRQ_MASK: rd_data = 32'(irq_mask);
            default: begin
                rd_data = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end
endmodule

// file: verif/far_props.sv
`timescale 1ns/1ps
module far_props #(
    parameter int unsigned TICK_CYCLES = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic overvolt_fault,
    input wire logic overcurrent_fault,
    input wire logic modulation_enable,
    input wire logic qs_ramp_select,
    input wire logic qs_torque_select
);
    int off_cnt;
    logic ov_seen;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence flt_held;
        (overvolt_fault || overcurrent_fault) [*6];
    endsequence
    sequence ar_taken;
        arvalid && arready;
    endsequence
    ////////////////////////////////////////////////////////////////
    // cycles spent with modulation off, and whether overvoltage caused it
    always_ff @(posedge aclk) begin
        off_cnt <= (!aresetn || modulation_enable) ? 0 : off_cnt + 1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ov_seen <= 1'b0;
        end else if (overvolt_fault) begin
            ov_seen <= 1'b1;
        end else if (modulation_enable && off_cnt == 0) begin
            ov_seen <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_ar_answer: assert property (ar_taken |=> rvalid && !arready) else $error("read late");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    chk_r_clear: assert property (rvalid && rready |=> !rvalid) else $error("rvalid stuck");
    chk_ar_idle: assert property (rvalid |-> !arready) else $error("arready during answer");
    chk_bad_read: assert property (ar_taken ##0 araddr == 8'h40 |=> rresp == 2'h2
        && rdata == 32'h0000_0000) else $error("unmapped read accepted");
    chk_fault_off: assert property (flt_held |-> !modulation_enable)
        else $error("modulating in fault");
    chk_ov_wait: assert property ($rose(modulation_enable) && ov_seen |->
        off_cnt >= 99 * TICK_CYCLES) else $error("overvoltage restart too soon");
    chk_qs_torque: assert property (qs_torque_select |-> qs_ramp_select)
        else $error("torque limit outside quick stop");
endmodule
bind far_top far_props #(.TICK_CYCLES(TICK_CYCLES)) far_props_i (.aclk, .aresetn, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .overvolt_fault, .overcurrent_fault,
    .modulation_enable, .qs_ramp_select, .qs_torque_select);

// file: verif/far_stage_model.sv
`timescale 1ns/1ps
module far_stage_model #(
    parameter int STOP_CYCLES = 30
) (
    input wire logic aclk,
    input wire logic modulation_enable,
    input wire logic qs_ramp_select,
    output logic standstill = 1'b1
);
    int cnt = 0;
    // motor coasts down while the quick stop ramp is selected
    always @(posedge aclk) begin
        cnt <= qs_ramp_select ? cnt + 1 : 0;
        standstill <= !modulation_enable || cnt >= STOP_CYCLES;
    end
endmodule

// file: verif/tb_far_top.sv
`timescale 1ns/1ps
module tb_far_top;
    import far_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic undervolt_fault = 0, overvolt_fault = 0, overcurrent_fault = 0, standstill;
    logic awready, wready, bvalid, arready, rvalid, modulation_enable, irq;
    logic quick_stop_active, qs_ramp_select, qs_torque_select, error_condition;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, wdata = 0;
    logic [7:0] awaddr = 0, araddr = 0, modulation_grade = 0;
    int error_cnt = 0, checks = 0, seed = 32'hdd51_b24a;
    logic [33:0] exp_q[$], exp_r;
    logic [1:0] exp_b[$];
    always #10 aclk = ~aclk;
    always @(posedge aclk) modulation_grade <= 8'($random(seed));
    far_top #(.TICK_CYCLES(2)) far_top_i (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .undervolt_fault, .overvolt_fault, .overcurrent_fault, .general_fault(1'b0),
        .standstill, .modulation_grade, .modulation_enable, .quick_stop_active, .qs_ramp_select,
        .qs_torque_select, .error_condition, .irq);
    far_stage_model far_stage_model_i (.aclk, .modulation_enable, .qs_ramp_select, .standstill);
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wait_hi(const ref logic s, input int lim = 60);
        int n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (s !== 1'b1 && n < lim);
        if (n >= lim) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] eb = RESP_OKAY);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
        exp_b.push_back(eb);
        fork
            begin
                wait_hi(awready);
                @(posedge aclk);
                awvalid <= 1'b0;
            end
            begin
                wait_hi(wready);
                @(posedge aclk);
                wvalid <= 1'b0;
            end
        join
        bready <= 1'b1;
        wait_hi(bvalid);
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        exp_q.push_back({er, e});
        wait_hi(arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        wait_hi(rvalid);
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    always @(negedge aclk) begin
        if (rvalid === 1'b1 && rready) begin
            exp_r = exp_q.pop_front();
            chk("rdata", exp_r[31:0], rdata);
            chk("rresp", {30'h0, exp_r[33:32]}, {30'h0, rresp});
        end
    end
    always @(negedge aclk) begin
        if (bvalid === 1'b1 && bready) begin
            chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, bresp});
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_RESTART_CFG, 32'h0000_0001);
        rd(8'h40, 32'h0000_0000, RESP_SLVERR);
        wr(OFS_RESTART_CFG, 32'h0000_0403);
        wr(OFS_DISP_OPT, 32'h0000_0100);
        wr(OFS_IRQ_MASK, 32'h0000_0008);
        wr(OFS_STATUS_A, 32'h0000_0000, RESP_SLVERR);
        wr(OFS_CONTROL_WORD, 32'h0000_0001);
        wait_hi(modulation_enable);
        rd(OFS_STATE_DISP, {24'h0, DISP_RUN});
        overvolt_fault <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(OFS_STATE_DISP, {24'h0, DISP_OV});
        overvolt_fault <= 1'b0;
        wait_hi(modulation_enable, 600);
        rd(OFS_STATE_DISP, {24'h0, DISP_RUN});
        $display("overvoltage restart test done");
        undervolt_fault <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(OFS_STATUS_A, 32'h0000_0008);
        @(negedge aclk);
        chk("error_condition", 32'h1, {31'h0, error_condition});
        @(posedge aclk);
        undervolt_fault <= 1'b0;
        wait_hi(modulation_enable);
        $display("undervoltage restart test done");
        wr(OFS_CONTROL_WORD, 32'h0000_0101);
        rd(OFS_STATE_DISP, {24'h0, DISP_QUICK_STOP});
        @(negedge aclk);
        chk("irq qs_active ramp torque error", 32'h1e, {27'h0, irq, quick_stop_active,
            qs_ramp_select, qs_torque_select, error_condition});
        wr(OFS_IRQ_STATUS, 32'h0000_000f);
        @(negedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        $display("quick stop test done");
        finish_test();
    end
endmodule
